// ===== core/hswc_pkg.sv
// package for the halt, standby and wake-up controller
// assumes one clock (clk) and a classic wishbone slave port with 32-bit data
package hswc_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CLOCK_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS     = 8'h04;
	localparam logic [7:0] OFS_WAKE_EN    = 8'h08;
	localparam logic [7:0] OFS_WDT_CTRL   = 8'h0c;
	localparam logic [7:0] OFS_WDT_LIMIT  = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;

	// system_clock_control fields
	localparam int POS_SLOW_HOLD = 0;
	localparam int POS_FAST_HOLD = 1;
	localparam int POS_CLK_SEL   = 5;
	localparam logic [7:0] RST_CLOCK_CTRL = 8'h00;

	// status fields
	localparam int POS_PD_FLAG  = 0;
	localparam int POS_WDT_FLAG = 1;
	localparam int POS_MODE     = 4;

	// watchdog control fields and reset values
	localparam int POS_WDT_EN = 0;
	localparam logic        RST_WDT_EN    = 1'b1;
	localparam logic [15:0] RST_WDT_LIMIT = 16'hffff;
	localparam logic [7:0]  RST_WAKE_EN   = 8'h00;

	// event bits of the interrupt status and mask registers
	localparam int EV_ENTER = 0;
	localparam int EV_WAKE  = 1;
	localparam int EV_WDT   = 2;
	localparam int EV_W     = 3;
	localparam logic [EV_W-1:0] RST_IRQ = 3'h0;

	// oscillator settle time after the stable indication, in ns
	localparam int CLK_MHZ        = 250;
	localparam int WAKE_SETTLE_NS = 1000;
	localparam int WAKE_SETTLE_CYC =
		(WAKE_SETTLE_NS * CLK_MHZ + 999) / 1000;

	typedef enum logic [2:0] {
		ST_RUN           = 3'b000,
		ST_DEEP_DOWN     = 3'b001,
		ST_STBY_SLOW     = 3'b010,
		ST_STBY_BOTH     = 3'b011,
		ST_STBY_FAST     = 3'b100,
		ST_WAKE          = 3'b101
	} hswc_state_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} hswc_wb_req_t;

	typedef struct packed {
		logic        haltExec;
		logic        clrWdtExec;
	} hswc_cpu_cmd_t;

	typedef struct packed {
		logic        resumeNext;
		logic        intService;
		logic        pcSpReset;
	} hswc_wake_rsp_t;

endpackage

// ===== core/hswc_halt_wake.sv
// halt, standby and wake-up controller with its register file
// assumes the cpu holds fetch while cpuHold is high and that the
// oscillator block reports fastOscStable once the fast clock runs
//
// Overview of operation
// - both holds zero: deep power-down, watchdog only
// - fast hold 0, slow 1: fast clock stops
// - both holds one: both clocks run, cpu halts
// - fast hold 1, slow 0: slow clock stops
// - any standby halts cpu, state is kept
// - entry sets power-down flag, clears expiry flag
// - entry clears watchdog counter, enable decides counting
// - wake on port edge, interrupt or overflow
// - power-down flag cleared only by reset, clear instruction
// - overflow in standby: expiry flag, pc/sp reset
// - per-pin wake enable, resume after halt
// - disabled or stack-full interrupt: resume, stays pending
// - enabled interrupt with free stack: service at once
// - request set before entry cannot wake
// - wake waits for oscillator restart and settle
// - fast hold bit 1, slow bit 0, reset 0
`timescale 1ns/1ps
module hswc_halt_wake
	import hswc_pkg::*;
(
	// clock and reset
	input  wire  logic                  clk,
	input  wire  logic                  resetn,
	// wishbone slave
	input  wire  hswc_pkg::hswc_wb_req_t wbReq,
	output logic [31:0]                 wbDatOut,
	output logic                        wbAck,
	output logic                        irq,
	// cpu side
	input  wire  hswc_pkg::hswc_cpu_cmd_t cpuCmd,
	output logic                        cpuHold,
	output hswc_pkg::hswc_wake_rsp_t     wakeRsp,
	// interrupt controller side
	input  wire  logic [7:0]            intRequest,
	input  wire  logic [7:0]            intEnable,
	input  wire  logic                  stackFull,
	// oscillators
	input  wire  logic                  fastOscStable,
	output logic                        fastClkEnable,
	output logic                        slowClkEnable,
	// port a pins
	input  wire  logic [7:0]            portA
);
	import hswc_pkg::*;

	hswc_state_t state;
	hswc_state_t next_state;

	logic [7:0]      clockCtrl;
	logic [7:0]      wakeEnable;
	logic            wdtEnable;
	logic [15:0]     wdtLimit;
	logic [15:0]     watchdogCounter;
	logic            powerDownFlag;
	logic            watchdogExpiryFlag;
	logic [EV_W-1:0] irqStatus;
	logic [EV_W-1:0] irqMask;
	logic [7:0]      intArmed;
	logic [7:0]      portSync1;
	logic [7:0]      portSync2;
	logic [7:0]      portLast;
	logic [8:0]      settleCount;
	logic            wakeWdt;
	logic            wakeInt;
	logic [7:0]      wakeIntVec;

	logic            wbWrite;
	logic            inStandby;
	logic            haltNow;
	logic            wdtOverflow;
	logic            portWake;
	logic            intWake;
	logic            anyWake;
	logic            settled;
	logic [EV_W-1:0] events;

	function automatic logic [7:0] merge8(input logic [7:0] old,
			input logic [7:0] nw, input logic en);
		merge8 = en ? nw : old;
	endfunction

	function automatic logic [EV_W-1:0] w1c(input logic [EV_W-1:0] cur,
			input logic [EV_W-1:0] clr, input logic [EV_W-1:0] set);
		w1c = (cur & ~clr) | set;
	endfunction

	// ---------------------------------------------------------------
	// bus slave: ack one cycle after the request, dropped after one
	// ---------------------------------------------------------------
	assign wbWrite = wbReq.cyc & wbReq.stb & wbReq.we & wbAck;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wbAck <= 1'b0;
		end else begin
			wbAck <= wbReq.cyc & wbReq.stb & ~wbAck;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wbDatOut <= 32'h0;
		end else if (wbReq.cyc && wbReq.stb && !wbAck) begin
			case (wbReq.adr)
				OFS_CLOCK_CTRL: wbDatOut <= {24'h0, clockCtrl};
				OFS_STATUS:     wbDatOut <= {25'h0, state, 2'h0,
					watchdogExpiryFlag, powerDownFlag};
				OFS_WAKE_EN:    wbDatOut <= {24'h0, wakeEnable};
				OFS_WDT_CTRL:   wbDatOut <= {31'h0, wdtEnable};
				OFS_WDT_LIMIT:  wbDatOut <= {16'h0, wdtLimit};
				OFS_IRQ_STATUS: wbDatOut <= {29'h0, irqStatus};
				OFS_IRQ_MASK:   wbDatOut <= {29'h0, irqMask};
				// unmapped offsets answer with zero
				default:        wbDatOut <= 32'h0;
			endcase
		end
	end

	// clock control: the hold bits steer the standby choice; the clock
	// select field is only stored, run-mode clock choice lives elsewhere
	always_ff @(posedge clk) begin
		if (!resetn) begin
			clockCtrl <= RST_CLOCK_CTRL;
		end else if (wbWrite && wbReq.adr == OFS_CLOCK_CTRL) begin
			// bits 4..2 are unimplemented and stay zero
			clockCtrl <= merge8(clockCtrl, wbReq.dat[7:0] & 8'he3,
				wbReq.sel[0]);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wakeEnable <= RST_WAKE_EN;
		end else if (wbWrite && wbReq.adr == OFS_WAKE_EN) begin
			wakeEnable <= merge8(wakeEnable, wbReq.dat[7:0],
				wbReq.sel[0]);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wdtEnable <= RST_WDT_EN;
			wdtLimit  <= RST_WDT_LIMIT;
		end else if (wbWrite) begin
			if (wbReq.adr == OFS_WDT_CTRL && wbReq.sel[0]) begin
				wdtEnable <= wbReq.dat[POS_WDT_EN];
			end
			if (wbReq.adr == OFS_WDT_LIMIT) begin
				wdtLimit <= {merge8(wdtLimit[15:8], wbReq.dat[15:8],
					wbReq.sel[1]), merge8(wdtLimit[7:0],
					wbReq.dat[7:0], wbReq.sel[0])};
			end
		end
	end

	// ---------------------------------------------------------------
	// wake sources
	// ---------------------------------------------------------------
	// pins may toggle with the fast clock stopped; two flops bring the
	// level in and the edge is seen on the second stage only
	always_ff @(posedge clk) begin
		if (!resetn) begin
			portSync1 <= 8'hff;
			portSync2 <= 8'hff;
			portLast  <= 8'hff;
		end else begin
			portSync1 <= portA;
			portSync2 <= portSync1;
			portLast  <= portSync2;
		end
	end

	assign inStandby = state == ST_DEEP_DOWN || state == ST_STBY_SLOW ||
		state == ST_STBY_BOTH || state == ST_STBY_FAST;
	assign portWake  = |(portLast & ~portSync2 & wakeEnable);
	assign wakeIntVec = intRequest & intArmed;
	assign intWake   = |wakeIntVec;
	assign wdtOverflow = wdtEnable && watchdogCounter == wdtLimit;
	assign anyWake   = portWake | intWake | wdtOverflow;
	assign haltNow   = state == ST_RUN && cpuCmd.haltExec;

	// requests already raised at entry are disarmed for wake-up; a level
	// request that was never cleared would otherwise wake at once and the
	// core could never stay down
	always_ff @(posedge clk) begin
		if (!resetn) begin
			intArmed <= 8'h00;
		end else if (haltNow) begin
			intArmed <= ~intRequest;
		end else if (state == ST_RUN) begin
			intArmed <= 8'h00;
		end
	end

	// watchdog runs in every mode, deep power-down included; it counts clk
	// here, so the limit register stands in for the slow divider chain
	always_ff @(posedge clk) begin
		if (!resetn) begin
			watchdogCounter <= 16'h0;
		end else if (haltNow || cpuCmd.clrWdtExec) begin
			watchdogCounter <= 16'h0;
		end else if (wdtOverflow) begin
			watchdogCounter <= 16'h0;
		end else if (wdtEnable) begin
			watchdogCounter <= watchdogCounter + 16'h1;
		end
	end

	// ---------------------------------------------------------------
	// mode sequencer
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (cpuCmd.haltExec) begin
					case ({clockCtrl[POS_FAST_HOLD],
							clockCtrl[POS_SLOW_HOLD]})
						2'b00:   next_state = ST_DEEP_DOWN;
						2'b01:   next_state = ST_STBY_SLOW;
						2'b11:   next_state = ST_STBY_BOTH;
						default: next_state = ST_STBY_FAST;
					endcase
				end
			end
			ST_DEEP_DOWN, ST_STBY_SLOW, ST_STBY_BOTH, ST_STBY_FAST: begin
				if (anyWake) begin
					next_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (settled) begin
					next_state = ST_RUN;
				end
			end
			default: next_state = ST_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	// the restarted oscillator must report stable, then settle a while
	assign settled = fastOscStable &&
		settleCount == WAKE_SETTLE_CYC[8:0];

	always_ff @(posedge clk) begin
		if (!resetn) begin
			settleCount <= 9'h0;
		end else if (state != ST_WAKE || !fastOscStable) begin
			settleCount <= 9'h0;
		end else if (!settled) begin
			settleCount <= settleCount + 9'h1;
		end
	end

	// wake cause, latched when leaving standby; overflow outranks others
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wakeWdt <= 1'b0;
			wakeInt <= 1'b0;
		end else if (inStandby && anyWake) begin
			wakeWdt <= wdtOverflow;
			wakeInt <= intWake & ~wdtOverflow;
		end
	end

	// one-cycle wake answer to the cpu at the end of the settle wait;
	// the request flag itself is left alone so it stays pending
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wakeRsp <= '0;
		end else begin
			wakeRsp <= '0;
			if (state == ST_WAKE && settled) begin
				if (wakeWdt) begin
					wakeRsp.pcSpReset <= 1'b1;
				end else if (wakeInt &&
						|(wakeIntVec & intEnable) && !stackFull) begin
					wakeRsp.intService <= 1'b1;
				end else begin
					wakeRsp.resumeNext <= 1'b1;
				end
			end
		end
	end

	// status flags
	always_ff @(posedge clk) begin
		if (!resetn) begin
			powerDownFlag <= 1'b0;
		end else if (haltNow) begin
			powerDownFlag <= 1'b1;
		end else if (cpuCmd.clrWdtExec) begin
			powerDownFlag <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			watchdogExpiryFlag <= 1'b0;
		end else if (inStandby && wdtOverflow) begin
			watchdogExpiryFlag <= 1'b1;
		end else if (haltNow) begin
			watchdogExpiryFlag <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// clock gating and cpu hold; memory and ports keep state because
	// the cpu is held and nothing here touches them
	// ---------------------------------------------------------------
	// the wake state turns both clocks back on so the oscillator can
	// restart before the settle count begins
	always_comb begin
		cpuHold = state != ST_RUN;
		fastClkEnable = 1'b1;
		slowClkEnable = 1'b1;
		case (state)
			ST_DEEP_DOWN: begin
				fastClkEnable = 1'b0;
				slowClkEnable = 1'b0;
			end
			ST_STBY_SLOW: begin
				fastClkEnable = 1'b0;
			end
			ST_STBY_FAST: begin
				slowClkEnable = 1'b0;
			end
			// run, wake and standby_both_clocks keep both clocks on
			default: begin
				fastClkEnable = 1'b1;
				slowClkEnable = 1'b1;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// interrupt status: set wins over a write-one clear
	// ---------------------------------------------------------------
	assign events = {inStandby & wdtOverflow,
		state == ST_WAKE & settled, haltNow};

	always_ff @(posedge clk) begin
		if (!resetn) begin
			irqStatus <= RST_IRQ;
			irqMask   <= RST_IRQ;
		end else begin
			irqStatus <= w1c(irqStatus,
				(wbWrite && wbReq.adr == OFS_IRQ_STATUS && wbReq.sel[0]) ?
				wbReq.dat[EV_W-1:0] : RST_IRQ, events);
			if (wbWrite && wbReq.adr == OFS_IRQ_MASK && wbReq.sel[0]) begin
				irqMask <= wbReq.dat[EV_W-1:0];
			end
		end
	end

	assign irq = |(irqStatus & irqMask);

endmodule

// ===== tb/hswc_halt_wake_monitor.sv
// port checker for the halt and wake controller
// assumes it is bound onto hswc_halt_wake, one clock domain
`timescale 1ns/1ps
module hswc_halt_wake_monitor
	import hswc_pkg::*;
(
	// clock and reset
	input wire logic                     clk,
	input wire logic                     resetn,
	// bus and cpu
	input wire hswc_pkg::hswc_wb_req_t   wbReq,
	input wire logic                     wbAck,
	input wire hswc_pkg::hswc_cpu_cmd_t  cpuCmd,
	input wire logic                     cpuHold,
	input wire hswc_pkg::hswc_wake_rsp_t wakeRsp,
	// oscillators
	input wire logic                     fastOscStable,
	input wire logic                     fastClkEnable,
	input wire logic                     slowClkEnable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	int stableCnt;
	// stable cycles seen while held; saturates so it cannot wrap
	always_ff @(posedge clk) begin
		if (!resetn || !cpuHold || !fastOscStable)
			stableCnt <= 0;
		else if (stableCnt < 1000)
			stableCnt <= stableCnt + 1;
	end
	chk_hold_on_halt: assert property (
		cpuCmd.haltExec && !cpuHold |=> cpuHold)
		else $error("halt did not hold the cpu");
	chk_run_clocks: assert property (
		!cpuHold |-> fastClkEnable && slowClkEnable)
		else $error("clock gated while running");
	chk_rsp_pulse: assert property (
		|wakeRsp |=> wakeRsp == '0)
		else $error("wake answer longer than one cycle");
	chk_rsp_single: assert property (
		$onehot0(wakeRsp))
		else $error("two wake answers at once");
	chk_rsp_release: assert property (
		|wakeRsp |-> !cpuHold && $past(cpuHold))
		else $error("wake answer without release");
	chk_hold_end: assert property (
		$fell(cpuHold) |-> |wakeRsp)
		else $error("hold ended without wake answer");
	chk_settle_wait: assert property (
		$fell(cpuHold) |-> stableCnt >= WAKE_SETTLE_CYC - 2)
		else $error("resumed before oscillator settled");
	chk_ack_next: assert property (
		wbReq.cyc && wbReq.stb && !wbAck |=> wbAck)
		else $error("bus request not answered");
	chk_ack_pulse: assert property (
		wbAck |=> !wbAck)
		else $error("ack longer than one cycle");
	cover property ($fell(cpuHold) && wakeRsp.intService);
	cover property ($fell(cpuHold) && wakeRsp.pcSpReset);
	cover property ($rose(cpuHold) && !fastClkEnable && !slowClkEnable);
endmodule

bind hswc_halt_wake hswc_halt_wake_monitor mon_u (.clk, .resetn, .wbReq,
	.wbAck, .cpuCmd, .cpuHold, .wakeRsp, .fastOscStable, .fastClkEnable,
	.slowClkEnable);

// ===== tb/hswc_cpu_model.sv
// cpu core and fast oscillator stand-in for the controller
// assumes the bench pulses goHalt and goClr for one cycle
`timescale 1ns/1ps
module hswc_cpu_model
	import hswc_pkg::*;
(
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    resetn,
	// bench requests
	input  wire logic                    goHalt,
	input  wire logic                    goClr,
	// controller side
	input  wire logic                    cpuHold,
	input  wire logic                    fastClkEnable,
	output hswc_pkg::hswc_cpu_cmd_t      cpuCmd,
	output logic                         fastOscStable
);
	logic [3:0] warm;
	// nothing is fetched while held, so no second stop is issued
	always_ff @(posedge clk) begin
		if (!resetn)
			cpuCmd <= '0;
		else begin
			cpuCmd.haltExec <= goHalt && !cpuHold;
			cpuCmd.clrWdtExec <= goClr && !cpuHold;
		end
	end
	// oscillator needs a few cycles to restart after enable
	always_ff @(posedge clk) begin
		warm <= fastClkEnable ? {warm[2:0], 1'b1} : 4'h0;
	end
	assign fastOscStable = warm[3];
endmodule

// ===== tb/hswc_halt_wake_test.sv
// self-checking bench for the halt and wake controller
// assumes the cpu model beside it and the bound checker
`timescale 1ns/1ps
module hswc_halt_wake_test;
	import hswc_pkg::*;
	logic           clk, resetn, goHalt, goClr, stackFull;
	hswc_wb_req_t   wbReq;
	hswc_cpu_cmd_t  cpuCmd;
	hswc_wake_rsp_t wakeRsp;
	logic [31:0]    wbDatOut, rd;
	logic [7:0]     intRequest, intEnable, portA;
	logic           wbAck, irq, cpuHold;
	logic           fastOscStable, fastClkEnable, slowClkEnable;
	int             n_errors = 0;
	int             comparisons = 0;

	hswc_halt_wake dut_u (.clk, .resetn, .wbReq, .wbDatOut, .wbAck,
		.irq, .cpuCmd, .cpuHold, .wakeRsp, .intRequest, .intEnable,
		.stackFull, .fastOscStable, .fastClkEnable, .slowClkEnable,
		.portA);
	hswc_cpu_model cpu_u (.clk, .resetn, .goHalt, .goClr, .cpuHold,
		.fastClkEnable, .cpuCmd, .fastOscStable);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input string what, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one classic cycle; read data lands in rd
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		wbReq <= '{1'b1, 1'b1, we, 4'hf, a, d};
		do
			@(posedge clk);
		while (wbAck !== 1'b1);
		rd = wbDatOut;
		wbReq <= '0;
	endtask

	task automatic enter(input logic [1:0] holds);
		wb(1'b1, OFS_CLOCK_CTRL, {30'h0, holds});
		@(posedge clk);
		goHalt <= 1'b1;
		@(posedge clk);
		goHalt <= 1'b0;
		repeat (3) @(posedge clk);
		chk("hold", 1, cpuHold);
		chk("fastEn", holds[1], fastClkEnable);
		chk("slowEn", holds[0], slowClkEnable);
		wb(1'b0, OFS_STATUS, 0);
		chk("pdFlag", 1, rd[POS_PD_FLAG]);
		chk("expiry", 0, rd[POS_WDT_FLAG]);
	endtask

	// waits for the wake answer; the global watchdog bounds a hang
	task automatic wake(input logic [2:0] exp);
		while (wakeRsp === 3'h0)
			@(negedge clk);
		chk("wakeRsp", exp, wakeRsp);
		chk("holdOff", 0, cpuHold);
		@(posedge clk);
	endtask

	task automatic port_wake;
		@(posedge clk);
		portA <= 8'hfe;
		wake(3'b100);
		portA <= 8'hff;
	endtask

	task automatic t_regs;
		wb(1'b0, OFS_CLOCK_CTRL, 0);
		chk("clkCtrl", RST_CLOCK_CTRL, rd);
		wb(1'b1, OFS_CLOCK_CTRL, 32'hff);
		wb(1'b0, OFS_CLOCK_CTRL, 0);
		chk("clkCtrl", 32'he3, rd);
		wb(1'b0, 8'h40, 0);
		chk("unmapped", 0, rd);
	endtask

	task automatic t_modes;
		wb(1'b1, OFS_WAKE_EN, 32'h01);
		for (int m = 0; m < 4; m++) begin
			enter(m[1:0]);
			port_wake();
		end
		chk("irqMasked", 0, irq);
		wb(1'b1, OFS_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq", 1, irq);
		wb(1'b1, OFS_IRQ_STATUS, 32'h7);
		repeat (2) @(posedge clk);
		chk("irqClr", 0, irq);
		wb(1'b0, OFS_STATUS, 0);
		chk("pdKept", 1, rd[POS_PD_FLAG]);
		goClr <= 1'b1;
		@(posedge clk);
		goClr <= 1'b0;
		repeat (3) @(posedge clk);
		wb(1'b0, OFS_STATUS, 0);
		chk("pdClr", 0, rd[POS_PD_FLAG]);
	endtask

	task automatic t_int;
		intEnable <= 8'h02;
		enter(2'b11);
		intRequest <= 8'h02;
		wake(3'b010);
		intRequest <= 8'h00;
		stackFull <= 1'b1;
		enter(2'b11);
		intRequest <= 8'h02;
		wake(3'b100);
		stackFull <= 1'b0;
		// request already pending and watchdog off: nothing may wake
		enter(2'b11);
		repeat (100) @(posedge clk);
		chk("stillHeld", 1, cpuHold);
		port_wake();
		intRequest <= 8'h00;
	endtask

	task automatic t_wdt;
		wb(1'b1, OFS_WDT_LIMIT, 32'd20);
		enter(2'b10);
		wb(1'b1, OFS_WDT_CTRL, 32'h1);
		wake(3'b001);
		wb(1'b1, OFS_WDT_CTRL, 32'h0);
		wb(1'b0, OFS_STATUS, 0);
		chk("expiry", 1, rd[POS_WDT_FLAG]);
		chk("pdKept", 1, rd[POS_PD_FLAG]);
	endtask

	task automatic final_report;
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		resetn = 1'b0;
		goHalt = 1'b0;
		goClr = 1'b0;
		stackFull = 1'b0;
		wbReq = '0;
		intRequest = 8'h00;
		intEnable = 8'h00;
		portA = 8'hff;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		wb(1'b0, OFS_WDT_CTRL, 0);
		chk("wdtEn", RST_WDT_EN, rd[POS_WDT_EN]);
		wb(1'b1, OFS_WDT_CTRL, 0);
		t_regs();
		t_modes();
		t_int();
		t_wdt();
		final_report();
	end

	// whole run needs a few thousand cycles
	initial begin
		#200000;
		n_errors++;
		final_report();
	end
endmodule
